// ===== src/tstq_pkg.sv
// How it works
// [R1] Push into a full queue sets overflow; with an advance pop that cycle, the push is stored unflagged.
// [R2] Overflow stays set until queue empties.
// [R3] Entry-valid shows a head entry exists.
// [R4] Status bits 26:21 show head identifier.
// [R5] Status bits 20:16 show head egress port.
// [R6] Status bits 15:0 show head sequence identifier.
// [R7] Status bit 29 flags OAM-requested stamps.
// [R8] Stamp bits 29:0 give departure plus delay.
// [R9] Stamp bit 31 is seconds LSB at event.
// [R10] Writing one to advance pops head entry.
// [R11] Status and delay follow new head entry.
// [R12] Six-bit stamp width field, reset 32.
// [R13] Two-bit rollover protection mode field.
// [R14] Writable sixteen-bit seconds bits 47:32.
// [R15] Writable 32-bit seconds bits 31:0.
// [R16] Read-only 30-bit nanosecond count exposed.
// [R17] Advance on empty queue changes nothing.
package tstq_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_STAMP = 8'h04;
  localparam logic [7:0] ADDR_ADVANCE = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_TOD_HIGH = 8'h10;
  localparam logic [7:0] ADDR_TOD_LOW = 8'h14;
  localparam logic [7:0] ADDR_TOD_NSEC = 8'h18;
  localparam logic [7:0] ADDR_DELAY = 8'h1C;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status register field positions.
  localparam int ST_OAM_BIT = 29;
  localparam int ST_OVFL_BIT = 28;
  localparam int ST_VALID_BIT = 27;

  // Stamp register field positions.
  localparam int SP_SEC_BIT = 31;

  // Configuration field positions and reset values.
  localparam int CFG_WID_LSB = 2;
  localparam int CFG_MODE_LSB = 0;
  localparam logic [5:0] CFG_WID_RESET = 6'h20;
  localparam logic [1:0] CFG_MODE_RESET = 2'h0;

  // Advance bit position.
  localparam int ADV_BIT = 0;

  // Time-of-day reset values.
  localparam logic [15:0] TOD_HIGH_RESET = 16'h0000;
  localparam logic [31:0] TOD_LOW_RESET = 32'h0000_0000;

  // Nanoseconds in one second, for wrapping the stamp sum.
  localparam logic [30:0] NS_PER_SEC = 31'h3B9A_CA00;

  // Queue geometry.
  localparam int QUEUE_DEPTH = 8;

  // Entry layout inside the queue word.
  localparam int EN_SEQ_LSB = 0;
  localparam int EN_PORT_LSB = 16;
  localparam int EN_ID_LSB = 21;
  localparam int EN_OAM_BIT = 27;
  localparam int EN_NS_LSB = 28;
  localparam int EN_SEC_BIT = 58;
  localparam int EN_DLY_LSB = 59;
  localparam int ENTRY_W = 75;

endpackage : tstq_pkg

// ===== src/tstq_queue.sv
`timescale 1ns/1ps
// Small flip-flop queue with a combinational view of the head word.
module tstq_queue
  import tstq_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic push_ready_o,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic empty_o
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH]; // Entry storage, indexed by pointer.
  logic [PTR_W-1:0] wr_ptr_ff; // Next free slot.
  logic [PTR_W-1:0] rd_ptr_ff; // Head slot.
  logic [PTR_W:0] count_ff; // Number of stored entries.

  wire full = (count_ff == (PTR_W+1)'(DEPTH));
  wire do_pop = pop_i && !empty_o;
  // A pop in the same cycle frees a slot, so a full queue still takes a push.
  wire do_push = push_i && (!full || do_pop);
  wire [PTR_W-1:0] wr_inc = (wr_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [PTR_W-1:0] rd_inc = (rd_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

  assign empty_o = (count_ff == '0);
  assign push_ready_o = !full || do_pop;
  assign head_o = mem_ff[rd_ptr_ff];

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_inc;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_inc;
      end
      count_ff <= count_ff + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
    end
  end

  // Storage has no reset; words are only read once counted in.
  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= push_data_i;
    end
  end

endmodule : tstq_queue

// ===== src/tstq_top.sv
`timescale 1ns/1ps
// Transmit timestamp queue and time-of-day registers behind an AXI4-Lite slave.
module tstq_top
  import tstq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address channel.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data channel.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address channel.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Timestamp events from the egress datapath.
  input wire logic stamp_event_i,
  input wire logic [5:0] stamp_identifier_i,
  input wire logic [4:0] stamp_egress_port_i,
  input wire logic [15:0] stamp_sequence_i,
  input wire logic stamp_oam_i,
  input wire logic [29:0] stamp_departure_ns_i,
  input wire logic [15:0] stamp_delay_i,
  output logic stamp_ready_o,
  // Configured transmit path delay in nanoseconds.
  input wire logic [29:0] tx_path_delay_i,
  // One-second timer inputs.
  input wire logic seconds_tick_i,
  input wire logic [29:0] nanosecond_count_i,
  // Configuration and time outputs for the rest of the subsystem.
  output logic [5:0] stamp_bit_width_o,
  output logic [1:0] rollover_protection_mode_o,
  output logic [47:0] seconds_counter_o
);

  // ---------------------------------------------------------------------------
  // Write channel state.
  // ---------------------------------------------------------------------------
  logic aw_held_ff; // Write address has been taken and waits for data.
  logic [ADDR_W-1:0] aw_addr_ff; // Captured write address.
  logic w_held_ff; // Write data has been taken and waits for address.
  logic [DATA_W-1:0] w_data_ff; // Captured write data.
  logic [3:0] w_strb_ff; // Captured byte strobes.
  logic bvalid_ff; // Write response pending.
  logic [1:0] bresp_ff; // Write response code.

  // ---------------------------------------------------------------------------
  // Read channel state.
  // ---------------------------------------------------------------------------
  logic rvalid_ff; // Read data pending.
  logic [DATA_W-1:0] rdata_ff; // Read data word.
  logic [1:0] rresp_ff; // Read response code.

  // ---------------------------------------------------------------------------
  // Software visible state.
  // ---------------------------------------------------------------------------
  logic [5:0] stamp_width_ff; // Stamp bit width field.
  logic [1:0] roll_mode_ff; // Rollover protection mode field.
  logic [15:0] tod_high_ff; // Seconds bits 47:32.
  logic [31:0] tod_low_ff; // Seconds bits 31:0.
  logic overflow_ff; // Sticky queue overflow flag.

  // ---------------------------------------------------------------------------
  // Channel handshakes. Each channel accepts one item and then stalls until
  // the response has gone, so at most one write and one read are in flight.
  // ---------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // The write is committed once both halves are held; this costs one cycle
  // but keeps the decode off the incoming bus wires.
  wire wr_commit = aw_held_ff && w_held_ff && !bvalid_ff;

  // ---------------------------------------------------------------------------
  // Write decode.
  // ---------------------------------------------------------------------------
  wire wr_hit_adv = (aw_addr_ff == ADDR_ADVANCE);
  wire wr_hit_cfg = (aw_addr_ff == ADDR_CONFIG);
  wire wr_hit_high = (aw_addr_ff == ADDR_TOD_HIGH);
  wire wr_hit_low = (aw_addr_ff == ADDR_TOD_LOW);
  // Read-only registers accept a write silently; only holes answer SLVERR.
  wire wr_mapped = wr_hit_adv || wr_hit_cfg || wr_hit_high || wr_hit_low ||
                   (aw_addr_ff == ADDR_STATUS) || (aw_addr_ff == ADDR_STAMP) ||
                   (aw_addr_ff == ADDR_TOD_NSEC) || (aw_addr_ff == ADDR_DELAY);

  // Byte-merged views of the writable words.
  wire [31:0] strb_mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                           {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  wire [31:0] cfg_word = {24'h00_0000, stamp_width_ff, roll_mode_ff};
  wire [31:0] cfg_merged = (cfg_word & ~strb_mask) | (w_data_ff & strb_mask);
  wire [31:0] low_merged = (tod_low_ff & ~strb_mask) | (w_data_ff & strb_mask);
  wire [31:0] high_word = {16'h0000, tod_high_ff};
  wire [31:0] high_merged = (high_word & ~strb_mask) | (w_data_ff & strb_mask);

  // The advance bit is one-shot: it acts on the write and never stores.
  wire advance_req = wr_commit && wr_hit_adv && w_strb_ff[0] && w_data_ff[ADV_BIT]; // [R10]

  // ---------------------------------------------------------------------------
  // Timestamp queue.
  // ---------------------------------------------------------------------------
  logic [ENTRY_W-1:0] head_entry; // Head-of-line entry word.
  logic queue_empty; // No entry stored.
  logic queue_ready; // Queue can take an entry this cycle.

  // Stamp is departure plus path delay, wrapped into one second of nanoseconds.
  wire [30:0] ns_sum = {1'b0, stamp_departure_ns_i} + {1'b0, tx_path_delay_i}; // [R8]
  wire [30:0] ns_wrapped = (ns_sum >= NS_PER_SEC) ? ns_sum - NS_PER_SEC : ns_sum;

  // The seconds LSB is taken from the live counter in the event cycle.
  wire [ENTRY_W-1:0] new_entry = {stamp_delay_i,
                                  tod_low_ff[0], // [R9]
                                  ns_wrapped[29:0],
                                  stamp_oam_i, // [R7]
                                  stamp_identifier_i,
                                  stamp_egress_port_i,
                                  stamp_sequence_i};

  // An event that finds the queue full, with no advance popping that cycle, is dropped and flagged.
  wire overflow_event = stamp_event_i && !queue_ready; // [R1]

  tstq_queue #(
    .WIDTH(ENTRY_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .push_i(stamp_event_i),
    .push_data_i(new_entry),
    .push_ready_o(queue_ready),
    .pop_i(advance_req), // [R17]
    .head_o(head_entry),
    .empty_o(queue_empty)
  );

  assign stamp_ready_o = queue_ready;

  // ---------------------------------------------------------------------------
  // Head entry fields. All follow the head pointer, so an advance exposes the
  // next entry in the cycle after the write commits.
  // ---------------------------------------------------------------------------
  wire entry_valid = !queue_empty; // [R3]
  // Fields read as zero while no entry is held, so stale words never show.
  wire [ENTRY_W-1:0] head_view = entry_valid ? head_entry : '0; // [R11]
  wire [5:0] entry_identifier = head_view[EN_ID_LSB +: 6];
  wire [4:0] entry_egress_port = head_view[EN_PORT_LSB +: 5];
  wire [15:0] entry_sequence_identifier = head_view[EN_SEQ_LSB +: 16];
  wire oam_origin_flag = head_view[EN_OAM_BIT];
  wire [29:0] entry_stamp_nanoseconds = head_view[EN_NS_LSB +: 30];
  wire entry_seconds_lsb = head_view[EN_SEC_BIT];
  wire [15:0] entry_delay_register = head_view[EN_DLY_LSB +: 16];

  // ---------------------------------------------------------------------------
  // Read words.
  // ---------------------------------------------------------------------------
  wire [31:0] status_word = {2'h0,
                             oam_origin_flag, // [R7]
                             overflow_ff,
                             entry_valid, // [R3]
                             entry_identifier, // [R4]
                             entry_egress_port, // [R5]
                             entry_sequence_identifier}; // [R6]
  wire [31:0] stamp_word = {entry_seconds_lsb, // [R9]
                            1'b0,
                            entry_stamp_nanoseconds}; // [R8]
  wire [31:0] nsec_word = {2'h0, nanosecond_count_i}; // [R16]
  wire [31:0] delay_word = {16'h0000, entry_delay_register}; // [R11]

  // Read decode; the advance register reads as zero.
  wire rd_hit_status = (s_axi_araddr == ADDR_STATUS);
  wire rd_hit_stamp = (s_axi_araddr == ADDR_STAMP);
  wire rd_hit_adv = (s_axi_araddr == ADDR_ADVANCE);
  wire rd_hit_cfg = (s_axi_araddr == ADDR_CONFIG);
  wire rd_hit_high = (s_axi_araddr == ADDR_TOD_HIGH);
  wire rd_hit_low = (s_axi_araddr == ADDR_TOD_LOW);
  wire rd_hit_nsec = (s_axi_araddr == ADDR_TOD_NSEC);
  wire rd_hit_delay = (s_axi_araddr == ADDR_DELAY);
  wire rd_mapped = rd_hit_status || rd_hit_stamp || rd_hit_adv || rd_hit_cfg ||
                   rd_hit_high || rd_hit_low || rd_hit_nsec || rd_hit_delay;
  wire [31:0] rd_word = rd_hit_status ? status_word :
                        rd_hit_stamp ? stamp_word :
                        rd_hit_cfg ? cfg_word :
                        rd_hit_high ? high_word :
                        rd_hit_low ? tod_low_ff :
                        rd_hit_nsec ? nsec_word :
                        rd_hit_delay ? delay_word : 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Next-state terms.
  // ---------------------------------------------------------------------------
  // A full queue is never empty, so set and clear cannot meet; set is listed
  // first anyway so that a drop can never be lost.
  wire nxt_overflow = overflow_event || (overflow_ff && !queue_empty); // [R1] [R2]

  // A software write to a seconds word wins over the timer tick that cycle.
  wire [47:0] seconds_inc = {tod_high_ff, tod_low_ff} + 48'h0000_0000_0001;
  wire [15:0] nxt_tod_high = (wr_commit && wr_hit_high) ? high_merged[15:0] :
                             seconds_tick_i ? seconds_inc[47:32] : tod_high_ff; // [R14]
  wire [31:0] nxt_tod_low = (wr_commit && wr_hit_low) ? low_merged :
                            seconds_tick_i ? seconds_inc[31:0] : tod_low_ff; // [R15]

  assign stamp_bit_width_o = stamp_width_ff;
  assign rollover_protection_mode_o = roll_mode_ff;
  assign seconds_counter_o = {tod_high_ff, tod_low_ff};

  // Write address capture.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Write data capture.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (w_take) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read response; data is frozen at the address handshake.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Transfer configuration; mode 3 is stored as written and left to the user.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stamp_width_ff <= CFG_WID_RESET; // [R12]
      roll_mode_ff <= CFG_MODE_RESET;
    end else if (wr_commit && wr_hit_cfg) begin
      stamp_width_ff <= cfg_merged[CFG_WID_LSB +: 6]; // [R12]
      roll_mode_ff <= cfg_merged[CFG_MODE_LSB +: 2]; // [R13]
    end
  end

  // Seconds counter and sticky overflow.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tod_high_ff <= TOD_HIGH_RESET;
      tod_low_ff <= TOD_LOW_RESET;
      overflow_ff <= 1'b0;
    end else begin
      tod_high_ff <= nxt_tod_high;
      tod_low_ff <= nxt_tod_low;
      overflow_ff <= nxt_overflow;
    end
  end

endmodule : tstq_top

// ===== verification/tstq_assertions.sv
`timescale 1ns/1ps
// Port-level checker; it sees only what the top module shows.
module tstq_assertions
  import tstq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic stamp_ready_o,
  input wire logic seconds_tick_i,
  input wire logic [29:0] nanosecond_count_i,
  input wire logic [5:0] stamp_bit_width_o,
  input wire logic [1:0] rollover_protection_mode_o,
  input wire logic [47:0] seconds_counter_o
);
  // Both write halves taken at one edge.
  wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // A read address taken at this edge.
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_nsec_read;
    rd_take && s_axi_araddr == ADDR_TOD_NSEC |=> s_axi_rdata[29:0] == $past(nanosecond_count_i);
  endproperty
  a_nsec_read: assert property (p_nsec_read)
    else $error("nanosecond read differs from counter input");
  // A full queue must report a valid head entry.
  property p_full_valid;
    rd_take && s_axi_araddr == ADDR_STATUS && !stamp_ready_o |=> s_axi_rdata[ST_VALID_BIT];
  endproperty
  a_full_valid: assert property (p_full_valid)
    else $error("full queue read without valid entry");
  property p_cfg_reset;
    $fell(rst_i) |-> stamp_bit_width_o == CFG_WID_RESET && rollover_protection_mode_o == 2'h0;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("configuration not at reset value");
  // Three edges cover the commit cycle.
  property p_cfg_write;
    wr_take && s_axi_awaddr == ADDR_CONFIG && s_axi_wstrb == 4'hF |-> ##3
      {stamp_bit_width_o, rollover_protection_mode_o} == $past(s_axi_wdata[7:0], 3);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not applied");
  property p_tod_low;
    wr_take && s_axi_awaddr == ADDR_TOD_LOW && s_axi_wstrb == 4'hF ##1 (!seconds_tick_i) [*3]
      |-> seconds_counter_o[31:0] == $past(s_axi_wdata, 3);
  endproperty
  a_tod_low: assert property (p_tod_low)
    else $error("low seconds write not applied");
  property p_tod_high;
    wr_take && s_axi_awaddr == ADDR_TOD_HIGH && s_axi_wstrb == 4'hF ##1 (!seconds_tick_i) [*3]
      |-> seconds_counter_o[47:32] == $past(s_axi_wdata[15:0], 3);
  endproperty
  a_tod_high: assert property (p_tod_high)
    else $error("high seconds write not applied");
  // A tick outside a pending write advances the whole 48-bit count by one.
  property p_tick;
    seconds_tick_i && s_axi_awready |=> seconds_counter_o == $past(seconds_counter_o) + 48'h1;
  endproperty
  a_tick: assert property (p_tick)
    else $error("seconds tick not counted");
  property p_adv_ready;
    wr_take && s_axi_awaddr == ADDR_ADVANCE && s_axi_wdata[0] && s_axi_wstrb[0] |=> stamp_ready_o;
  endproperty
  a_adv_ready: assert property (p_adv_ready)
    else $error("advance did not free a queue slot");
endmodule : tstq_assertions

bind tstq_top tstq_assertions u_chk (.sys_clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .stamp_ready_o, .seconds_tick_i,
  .nanosecond_count_i, .stamp_bit_width_o, .rollover_protection_mode_o, .seconds_counter_o);

// ===== verification/test_tstq_top.sv
`timescale 1ns/1ps
// Register-level bench: tasks note expected answers, a monitor compares them.
module test_tstq_top;
  import tstq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ev = 1'b0, ev_oam = 1'b0, tick = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [5:0] ev_id = '0;
  logic [4:0] ev_port = '0;
  logic [15:0] ev_seq = '0, ev_dly = '0;
  logic [29:0] ev_dep = '0, nsec = '0;
  logic [29:0] path_dly = 30'h3B00_0000; // Large, so that many sums wrap past one second.
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ev_ready;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int num_errors = 0;
  int checked = 0;
  logic [33:0] exp_q[$]; // Expected {resp, data}, in the order the answers arrive.
  logic [31:0] st_q[$], sp_q[$], dl_q[$]; // Reference copy of the queued entries.
  logic ovf = 1'b0;
  logic [47:0] sec_m = '0;
  logic [15:0] lfsr_st = 16'h0063;

  tstq_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .stamp_event_i(ev), .stamp_identifier_i(ev_id), .stamp_egress_port_i(ev_port),
    .stamp_sequence_i(ev_seq), .stamp_oam_i(ev_oam), .stamp_departure_ns_i(ev_dep),
    .stamp_delay_i(ev_dly), .stamp_ready_o(ev_ready), .tx_path_delay_i(path_dly),
    .seconds_tick_i(tick), .nanosecond_count_i(nsec), .stamp_bit_width_o(),
    .rollover_protection_mode_o(), .seconds_counter_o());

  // Free-running system clock.
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Pseudo-random words from a 16-bit shift register.
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
      rnd[i] = lfsr_st[0];
    end
  endfunction : rnd

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected answer at %0t: expected %h got %h", $time, e, g);
    end
  endtask : check

  // Each accepted answer retires the oldest note; bus transfers are strictly serial.
  always @(posedge sys_clk_i) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check(exp_q.pop_front(), {s_axi_bresp, 32'h0});
  end

  // Offers address and data together and waits for the response, bounded.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 40) begin
        num_errors++;
        report_and_stop();
      end
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge sys_clk_i); // Keeps the next raise of the handshake in another time step.
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 40) begin
        num_errors++;
        report_and_stop();
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd

  // Presents one event for one edge and updates the reference queue.
  task automatic push_ev();
    logic [31:0] a, b;
    logic [30:0] s;
    a = rnd();
    b = rnd();
    s = {2'b00, b[28:0]} + {1'b0, path_dly};
    if (s >= NS_PER_SEC) s = s - NS_PER_SEC;
    if (st_q.size() < QUEUE_DEPTH) begin
      st_q.push_back({2'b00, a[31], 2'b00, a[5:0], a[10:6], a[27:12]});
      sp_q.push_back({sec_m[0], 1'b0, s[29:0]});
      dl_q.push_back({16'h0000, a[11], b[31:29], a[31:20]});
    end else begin
      ovf = 1'b1; // The event is dropped and the overflow flag latches.
    end
    ev <= 1'b1;
    ev_id <= a[5:0];
    ev_port <= a[10:6];
    ev_seq <= a[27:12];
    ev_oam <= a[31];
    ev_dep <= {1'b0, b[28:0]};
    ev_dly <= {a[11], b[31:29], a[31:20]};
    @(posedge sys_clk_i);
  endtask : push_ev

  // Main sequence.
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(ADDR_CONFIG, 32'h0000_0080);
    rd(ADDR_TOD_HIGH, 32'h0000_0000);
    rd(ADDR_TOD_LOW, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_ADVANCE, 32'h0000_0001);
    rd(ADDR_STATUS, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000, RESP_SLVERR);
    wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
    r = rnd();
    nsec <= r[29:0];
    rd(ADDR_TOD_NSEC, {2'b00, r[29:0]});
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      wr(ADDR_CONFIG, {24'h000000, r[5:0], m[1:0]});
      rd(ADDR_CONFIG, {24'h000000, r[5:0], m[1:0]});
    end
    r = rnd();
    sec_m[47:32] = r[15:0];
    wr(ADDR_TOD_HIGH, r);
    rd(ADDR_TOD_HIGH, {16'h0000, r[15:0]});
    r = rnd() | 32'h0000_0001;
    sec_m[31:0] = r;
    wr(ADDR_TOD_LOW, r);
    rd(ADDR_TOD_LOW, r);
    // Nine back-to-back events: the ninth finds the queue full.
    repeat (QUEUE_DEPTH + 1) push_ev();
    ev <= 1'b0;
    wr(ADDR_ADVANCE, 32'hFFFF_FFFE);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    while (st_q.size() > 0) begin
      rd(ADDR_STATUS, st_q[0] | {3'b000, ovf, 1'b1, 27'h0});
      rd(ADDR_STAMP, sp_q[0]);
      rd(ADDR_DELAY, dl_q[0]);
      wr(ADDR_ADVANCE, 32'h0000_0001);
      void'(st_q.pop_front());
      void'(sp_q.pop_front());
      void'(dl_q.pop_front());
      if (st_q.size() == 0) ovf = 1'b0;
    end
    rd(ADDR_STATUS, 32'h0000_0000);
    tick <= 1'b1;
    @(posedge sys_clk_i);
    tick <= 1'b0;
    sec_m = sec_m + 48'h1;
    rd(ADDR_TOD_LOW, sec_m[31:0]);
    report_and_stop();
  end
endmodule : test_tstq_top
